// ===== include/efp_map.vh
// Constants for the receive address filter and parser
// What this block does
// - Hold one station address in two 32-bit words; accept frames addressed to it.
// - On station miss with extended features on, try four extra addresses.
// - Accept broadcast when enabled; accept everything when promiscuous.
// - Basic mode puts every accepted frame in one single queue.
// - Without promiscuous or broadcast, drop frames matching no address.
// - Extended mode classifies on MAC, IP and TCP/UDP header fields.
// - Extended mode spreads frames over several receive queues.
// - Eight descriptor rings are the bins; matched frames go only there.
// - Parse commands extract fields, looked up in a key/termination hash table.
// - Signal transmit events to the host cores.
// - Signal receive errors to the host cores.
// - Handle untagged frames: preamble, delimiter, addresses, type, payload, check.
// - Line side may be any supported MII variant at its rate.
`ifndef EFP_MAP_VH
`define EFP_MAP_VH

// ------------------------------------------------------------------
// Frame layout (byte indices after the delimiter)
// ------------------------------------------------------------------
`define EFP_PREAMBLE     8'h55
`define EFP_SFD          8'hd5
`define EFP_HDR_BYTES    38
`define EFP_POS_DST      0
`define EFP_POS_SRC      6
`define EFP_POS_TYPE     12
`define EFP_POS_IPPROTO  23
`define EFP_POS_IPSRC    26
`define EFP_POS_IPDST    30
`define EFP_POS_L4SRC    34
`define EFP_POS_L4DST    36
`define EFP_MIN_LEN      11'h040
`define EFP_MAX_LEN      11'h5ee
`define EFP_TYPE_IP      16'h0800
`define EFP_PROTO_TCP    8'h06
`define EFP_PROTO_UDP    8'h11

// ------------------------------------------------------------------
// Check sequence
// ------------------------------------------------------------------
`define EFP_CRC_POLY     32'hedb88320
`define EFP_CRC_INIT     32'hffffffff
`define EFP_CRC_RESIDUE  32'hdebb20e3

// ------------------------------------------------------------------
// Status bit positions and reset values
// ------------------------------------------------------------------
`define EFP_RX_FCS       0
`define EFP_RX_ALIGN     1
`define EFP_RX_SHORT     2
`define EFP_RX_LONG      3
`define EFP_RX_OVERRUN   4
`define EFP_RX_BUSY      5
`define EFP_RX_STAT_RST  6'h00
`define EFP_TX_STAT_RST  7'h00

`endif

// ===== rtl/efp_rx_filter.v
// Receive address filter, header parser and frame descriptor queue
`timescale 1ns/100ps
`include "efp_map.vh"

// ------------------------------------------------------------------
// Descriptor FIFO with registered output stage
// ------------------------------------------------------------------
module efp_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire            push = in_valid & in_ready;
  wire            pop  = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  assign in_ready = (cnt_q != DEPTH[AW:0]);

  // Storage write, no reset needed
  always @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  // Pointers, fill count and output stage
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_q      <= {AW{1'b0}};
      rp_q      <= {AW{1'b0}};
      cnt_q     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q      <= rp_q + 1'b1;
        out_data  <= mem[rp_q];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // efp_fifo

// ------------------------------------------------------------------
// Top: filter, parser, error flags
// ------------------------------------------------------------------
module efp_rx_filter #(
  parameter TBL_AW = 4,
  parameter QDEPTH = 16
) (
  input  wire         CLK,
  input  wire         RESET,
  input  wire         RX_DV,
  input  wire [7:0]   RX_D,
  input  wire         RX_ER,
  input  wire         RX_ODD,
  input  wire [31:0]  STATION_HI,
  input  wire [31:0]  STATION_LO,
  input  wire [191:0] EXTRA_ADDR,
  input  wire         EXT_FEAT_EN,
  input  wire         BCAST_EN,
  input  wire         PROMISC_EN,
  input  wire         PARSE_EN,
  input  wire [7:0]   KEY_SEL,
  input  wire         DEF_RING_EN,
  input  wire [2:0]   DEF_RING,
  input  wire [7:0]   RING_FREE,
  input  wire         TBL_WR,
  input  wire [3:0]   TBL_IDX,
  input  wire [31:0]  TBL_KEY,
  input  wire [2:0]   TBL_RING,
  input  wire         TBL_VLD,
  input  wire [6:0]   TX_EVT,
  input  wire [6:0]   TX_CLR,
  input  wire [5:0]   RX_CLR,
  output wire         Q_VALID,
  input  wire         Q_READY,
  output wire [2:0]   Q_RING,
  output wire [10:0]  Q_LEN,
  output reg  [6:0]   TX_STAT,
  output reg  [5:0]   RX_STAT,
  output reg          EVT_IRQ
);
  localparam ST_IDLE = 2'd0;
  localparam ST_PRE  = 2'd1;
  localparam ST_BODY = 2'd2;

  reg  [1:0]   state_q;
  reg  [10:0]  len_q;
  reg  [31:0]  crc_q;
  reg  [303:0] hdr_q;
  reg          bad_q;
  reg          odd_q;
  reg  [31:0]  tkey_q [0:(1<<TBL_AW)-1];
  reg  [2:0]   tring_q [0:(1<<TBL_AW)-1];
  reg  [(1<<TBL_AW)-1:0] tvld_q;

  // Bytewise reflected CRC-32 update
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg   [31:0] r;
    begin
      r = c ^ {24'h000000, d};
      for (i = 0; i < 8; i = i + 1) begin
        r = r[0] ? ((r >> 1) ^ `EFP_CRC_POLY) : (r >> 1);
      end
      crc_byte = r;
    end
  endfunction

  // Fold a 48-bit value into 32 bits
  function [31:0] fold48;
    input [47:0] x;
    begin
      fold48 = {16'h0000, x[47:32]} ^ x[31:0];
    end
  endfunction

  // ------------------------------------------------------------------
  // Receive state machine: byte stream from any MII variant
  // ------------------------------------------------------------------
  wire frame_end = (state_q == ST_BODY) & ~RX_DV;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      len_q   <= 11'h000;
      crc_q   <= `EFP_CRC_INIT;
      hdr_q   <= {304{1'b0}};
      bad_q   <= 1'b0;
      odd_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (RX_DV && RX_D == `EFP_PREAMBLE) begin
            state_q <= ST_PRE;
          end
        end
        ST_PRE: begin // Preamble then delimiter
          len_q <= 11'h000;
          crc_q <= `EFP_CRC_INIT;
          bad_q <= 1'b0;
          odd_q <= 1'b0;
          if (!RX_DV) begin
            state_q <= ST_IDLE;
          end else if (RX_D == `EFP_SFD) begin
            state_q <= ST_BODY;
          end else if (RX_D != `EFP_PREAMBLE) begin
            state_q <= ST_IDLE;
          end
        end
        ST_BODY: begin
          if (RX_DV) begin
            crc_q <= crc_byte(crc_q, RX_D);
            if (len_q != 11'h7ff) begin
              len_q <= len_q + 11'h001;
            end
            if (len_q < `EFP_HDR_BYTES) begin // Keep the header bytes
              hdr_q <= {hdr_q[295:0], RX_D};
            end
            bad_q <= bad_q | RX_ER;
            odd_q <= odd_q | RX_ODD;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Header field extraction
  // ------------------------------------------------------------------
  wire [47:0] f_dst   = hdr_q[(37-`EFP_POS_DST)*8-40 +: 48];
  wire [47:0] f_src   = hdr_q[(37-`EFP_POS_SRC)*8-40 +: 48];
  wire [15:0] f_type  = hdr_q[(37-`EFP_POS_TYPE)*8-8 +: 16];
  wire [7:0]  f_proto = hdr_q[(37-`EFP_POS_IPPROTO)*8 +: 8];
  wire [31:0] f_ipsrc = hdr_q[(37-`EFP_POS_IPSRC)*8-24 +: 32];
  wire [31:0] f_ipdst = hdr_q[(37-`EFP_POS_IPDST)*8-24 +: 32];
  wire [15:0] f_l4src = hdr_q[(37-`EFP_POS_L4SRC)*8-8 +: 16];
  wire [15:0] f_l4dst = hdr_q[(37-`EFP_POS_L4DST)*8-8 +: 16];
  wire        is_ip   = (f_type == `EFP_TYPE_IP);
  wire        is_l4   = is_ip & ((f_proto == `EFP_PROTO_TCP) | (f_proto == `EFP_PROTO_UDP));

  // ------------------------------------------------------------------
  // Address filter
  // ------------------------------------------------------------------
  wire [3:0] extra_hit;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_extra
      assign extra_hit[g] = (f_dst == EXTRA_ADDR[g*48 +: 48]);
    end
  endgenerate

  wire sta_hit  = (f_dst == {STATION_HI[15:0], STATION_LO});
  wire bc_hit   = BCAST_EN & (f_dst == 48'hffffffffffff);
  // Misses with neither broadcast nor promiscuous are discarded
  wire addr_ok  = PROMISC_EN | bc_hit | sta_hit |
                  (EXT_FEAT_EN & (|extra_hit));

  // ------------------------------------------------------------------
  // Key build and hash lookup
  // ------------------------------------------------------------------
  wire [31:0] key = (KEY_SEL[0] ? fold48(f_dst) : 32'h0) ^
                    (KEY_SEL[1] ? fold48(f_src) : 32'h0) ^
                    (KEY_SEL[2] ? {16'h0000, f_type} : 32'h0) ^
                    ((KEY_SEL[3] & is_ip) ? f_ipsrc : 32'h0) ^
                    ((KEY_SEL[4] & is_ip) ? f_ipdst : 32'h0) ^
                    ((KEY_SEL[5] & is_ip) ? {24'h000000, f_proto} : 32'h0) ^
                    ((KEY_SEL[6] & is_l4) ? {16'h0000, f_l4src} : 32'h0) ^
                    ((KEY_SEL[7] & is_l4) ? {f_l4dst, 16'h0000} : 32'h0);
  wire [15:0] k16   = key[31:16] ^ key[15:0];
  wire [7:0]  k8    = k16[15:8] ^ k16[7:0];
  wire [3:0]  hidx  = k8[7:4] ^ k8[3:0];
  wire [TBL_AW-1:0] tidx = hidx[TBL_AW-1:0];
  wire        thit  = tvld_q[tidx] & (tkey_q[tidx] == key);

  // Termination table written by software
  always @(posedge CLK) begin
    if (TBL_WR) begin
      tkey_q[TBL_IDX[TBL_AW-1:0]]  <= TBL_KEY;
      tring_q[TBL_IDX[TBL_AW-1:0]] <= TBL_RING;
    end
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tvld_q <= {(1<<TBL_AW){1'b0}};
    end else if (TBL_WR) begin
      tvld_q[TBL_IDX[TBL_AW-1:0]] <= TBL_VLD;
    end
  end

  // ------------------------------------------------------------------
  // Ring choice and frame verdict
  // ------------------------------------------------------------------
  wire [2:0] ring = !PARSE_EN ? 3'd0 :
                    thit ? tring_q[tidx] : DEF_RING;
  wire parse_ok   = !PARSE_EN | thit | DEF_RING_EN;
  wire crc_bad    = (crc_q != `EFP_CRC_RESIDUE) | bad_q;
  wire too_short  = (len_q < `EFP_MIN_LEN);
  wire too_long   = (len_q > `EFP_MAX_LEN);
  wire frame_good = ~crc_bad & ~odd_q & ~too_short & ~too_long;
  wire want       = frame_end & frame_good & addr_ok & parse_ok;
  wire no_buf     = ~RING_FREE[ring];
  wire q_ready;
  wire push       = want & ~no_buf & q_ready;

  efp_fifo #(
    .WIDTH (14),
    .DEPTH (QDEPTH),
    .AW    (4)
  ) u_queue (
    .clk       (CLK),
    .reset     (RESET),
    .in_valid  (push),
    .in_ready  (q_ready),
    .in_data   ({ring, len_q}),
    .out_valid (Q_VALID),
    .out_ready (Q_READY),
    .out_data  ({Q_RING, Q_LEN})
  );

  // ------------------------------------------------------------------
  // Sticky event flags; a new event beats a clear
  // ------------------------------------------------------------------
  wire [5:0] rx_evt;
  assign rx_evt[`EFP_RX_FCS]     = frame_end & crc_bad;
  assign rx_evt[`EFP_RX_ALIGN]   = frame_end & odd_q;
  assign rx_evt[`EFP_RX_SHORT]   = frame_end & too_short;
  assign rx_evt[`EFP_RX_LONG]    = frame_end & too_long;
  assign rx_evt[`EFP_RX_OVERRUN] = want & ~no_buf & ~q_ready;
  assign rx_evt[`EFP_RX_BUSY]    = want & no_buf;

  wire [5:0] rx_stat_d = (RX_STAT & ~RX_CLR) | rx_evt;
  wire [6:0] tx_stat_d = (TX_STAT & ~TX_CLR) | TX_EVT;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RX_STAT <= `EFP_RX_STAT_RST;
      TX_STAT <= `EFP_TX_STAT_RST;
      EVT_IRQ <= 1'b0;
    end else begin
      RX_STAT <= rx_stat_d;
      TX_STAT <= tx_stat_d;
      EVT_IRQ <= (|rx_stat_d) | (|tx_stat_d);
    end
  end
endmodule // efp_rx_filter

// ===== sim/efp_rx_chk.sv
// Checker for the receive filter status flags and descriptor queue
`timescale 1ns/100ps
module efp_rx_chk (
  input wire        CLK,
  input wire        RESET,
  input wire        PARSE_EN,
  input wire [6:0]  TX_EVT,
  input wire [6:0]  TX_CLR,
  input wire [5:0]  RX_CLR,
  input wire        Q_VALID,
  input wire        Q_READY,
  input wire [2:0]  Q_RING,
  input wire [10:0] Q_LEN,
  input wire [6:0]  TX_STAT,
  input wire [5:0]  RX_STAT,
  input wire        EVT_IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ------------------------------------------------------------------
  // Sticky flags and interrupt
  // ------------------------------------------------------------------
  property p_irq_or; EVT_IRQ == (|{TX_STAT, RX_STAT}); endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not OR of flags");
  property p_tx_set;
    (TX_EVT != 7'h00) |=> ((TX_STAT & $past(TX_EVT)) == $past(TX_EVT));
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx event not latched");
  property p_tx_hold;
    1'b1 |=> ((TX_STAT & $past(TX_STAT) & ~$past(TX_CLR)) == ($past(TX_STAT) & ~$past(TX_CLR)));
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx flag lost");
  property p_tx_clr;
    1'b1 |=> ((TX_STAT & $past(TX_CLR) & ~$past(TX_EVT)) == 7'h00);
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx flag not cleared");
  property p_rx_hold;
    1'b1 |=> ((RX_STAT & $past(RX_STAT) & ~$past(RX_CLR)) == ($past(RX_STAT) & ~$past(RX_CLR)));
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx flag lost");
  // ------------------------------------------------------------------
  // Descriptor queue
  // ------------------------------------------------------------------
  property p_q_stand;
    Q_VALID && !Q_READY |=> Q_VALID && $stable(Q_RING) && $stable(Q_LEN);
  endproperty
  a_q_stand: assert property (p_q_stand) else $error("descriptor dropped");
  property p_ring0; Q_VALID && !PARSE_EN |-> Q_RING == 3'h0; endproperty
  a_ring0: assert property (p_ring0) else $error("basic mode ring not 0");
  property p_len; Q_VALID |-> Q_LEN >= 11'h040 && Q_LEN <= 11'h5ee; endproperty
  a_len: assert property (p_len) else $error("bad length queued");
endmodule // efp_rx_chk

bind efp_rx_filter efp_rx_chk u_chk (.CLK(CLK), .RESET(RESET), .PARSE_EN(PARSE_EN),
  .TX_EVT(TX_EVT), .TX_CLR(TX_CLR), .RX_CLR(RX_CLR), .Q_VALID(Q_VALID), .Q_READY(Q_READY),
  .Q_RING(Q_RING), .Q_LEN(Q_LEN), .TX_STAT(TX_STAT), .RX_STAT(RX_STAT), .EVT_IRQ(EVT_IRQ));

// ===== sim/efp_phy_model.sv
// Line-side PHY model sending whole frames with check sequence
`timescale 1ns/100ps
module efp_phy_model (
  input  wire        clk,
  output logic       rx_dv,
  output logic [7:0] rx_d,
  output logic       rx_er,
  output logic       rx_odd
);
  logic [7:0] body [0:1599];
  initial begin
    rx_dv = 1'b0; rx_d = 8'h00; rx_er = 1'b0; rx_odd = 1'b0;
  end
  // Send n body bytes; err 1 bad check, 2 line error, 3 dribble, 4 IPv4/UDP header
  task automatic send(input logic [47:0] dst, input int n, input int err);
    logic [31:0] crc;
    crc = 32'hffffffff;
    for (int i = 0; i < n; i++) begin
      if (i < 6) body[i] = dst[47-8*i -: 8];
      else if (err == 4 && i == 12) body[i] = 8'h08;
      else if (err == 4 && (i == 13 || i == 23)) body[i] = (i == 13) ? 8'h00 : 8'h11;
      else if (i < n - 4) body[i] = i[7:0];
      else body[i] = ~crc[8*(i-n+4) +: 8] ^ ((err == 1) ? 8'h01 : 8'h00);
      if (i < n - 4) begin
        crc = crc ^ {24'h0, body[i]};
        repeat (8) crc = crc[0] ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
      end
    end
    // Seven preamble bytes, delimiter, then body
    for (int i = -8; i < n; i++) begin
      @(negedge clk);
      rx_dv = 1'b1;
      rx_d = (i < -1) ? 8'h55 : (i < 0) ? 8'hd5 : body[i];
      rx_er = (err == 2 && i == 20);
      rx_odd = (err == 3 && i == 20);
    end
    @(negedge clk);
    rx_dv = 1'b0; rx_er = 1'b0; rx_odd = 1'b0;
    rx_d = ~rx_d;
  endtask
endmodule // efp_phy_model

// ===== sim/tb_top.sv
// Self-checking testbench for the receive filter
`timescale 1ns/100ps
module tb_top;
  localparam logic [47:0]  ST = 48'h0a1b2c3d4e5f;
  localparam logic [191:0] XA = {48'h02aa55000003, 48'h02aa55000002,
                                 48'h02aa55000001, 48'h02aa55000000};
  logic CLK = 0, RESET = 1, PARSE_EN = 0, EXT_FEAT_EN = 0, BCAST_EN = 0, PROMISC_EN = 0;
  logic DEF_RING_EN = 0, TBL_WR = 0, TBL_VLD = 0, Q_READY = 0;
  logic [7:0]  KEY_SEL = 8'h01, RING_FREE = 8'hff;
  logic [3:0]  TBL_IDX = 4'h0;
  logic [31:0] TBL_KEY = 32'h0;
  logic [2:0]  DEF_RING = 3'h0, TBL_RING = 3'h0;
  logic [6:0]  TX_EVT = 7'h00, TX_CLR = 7'h00;
  logic [5:0]  RX_CLR = 6'h00;
  wire         RX_DV, RX_ER, RX_ODD, Q_VALID, EVT_IRQ;
  wire [7:0]   RX_D;
  wire [2:0]   Q_RING;
  wire [10:0]  Q_LEN;
  wire [6:0]   TX_STAT;
  wire [5:0]   RX_STAT;
  int          fail_count = 0, checks_done = 0, cyc = 0;
  // Clock and hang guard
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      print_verdict();
    end
  end
  efp_phy_model phy (.clk(CLK), .rx_dv(RX_DV), .rx_d(RX_D), .rx_er(RX_ER), .rx_odd(RX_ODD));
  efp_rx_filter dut (.CLK(CLK), .RESET(RESET), .RX_DV(RX_DV), .RX_D(RX_D), .RX_ER(RX_ER),
    .RX_ODD(RX_ODD), .STATION_HI({16'h0, ST[47:32]}), .STATION_LO(ST[31:0]),
    .EXTRA_ADDR(XA), .EXT_FEAT_EN(EXT_FEAT_EN), .BCAST_EN(BCAST_EN), .PROMISC_EN(PROMISC_EN),
    .PARSE_EN(PARSE_EN), .KEY_SEL(KEY_SEL), .DEF_RING_EN(DEF_RING_EN), .DEF_RING(DEF_RING),
    .RING_FREE(RING_FREE), .TBL_WR(TBL_WR), .TBL_IDX(TBL_IDX), .TBL_KEY(TBL_KEY),
    .TBL_RING(TBL_RING), .TBL_VLD(TBL_VLD), .TX_EVT(TX_EVT), .TX_CLR(TX_CLR), .RX_CLR(RX_CLR),
    .Q_VALID(Q_VALID), .Q_READY(Q_READY), .Q_RING(Q_RING), .Q_LEN(Q_LEN), .TX_STAT(TX_STAT),
    .RX_STAT(RX_STAT), .EVT_IRQ(EVT_IRQ));
  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Wait for a descriptor, compare it and take it
  task automatic expect_q(input logic [2:0] r, input logic [10:0] l);
    int k;
    k = 0;
    // Let an edge pass so Q_READY never toggles twice in one step
    @(negedge CLK);
    while (Q_VALID !== 1'b1 && k < 20) begin
      @(negedge CLK);
      k++;
    end
    chk(Q_VALID, 1); chk(Q_RING, r); chk(Q_LEN, l);
    Q_READY = 1'b1;
    @(negedge CLK);
    Q_READY = 1'b0;
  endtask
  task automatic expect_none();
    repeat (5) @(negedge CLK);
    chk(Q_VALID, 0);
  endtask
  // Check one receive flag, then clear it
  task automatic rx_flag(input logic [5:0] exp, input logic qv);
    repeat (3) @(negedge CLK);
    chk(RX_STAT, exp); chk(EVT_IRQ, 1); chk(Q_VALID, qv);
    RX_CLR = 6'h3f;
    @(negedge CLK);
    RX_CLR = 6'h00;
    chk(RX_STAT, 0); chk(EVT_IRQ, 0);
  endtask
  function automatic logic [31:0] key_of(input int k);
    case (k)
      0: key_of = {16'h0, ST[47:32]} ^ ST[31:0];
      1: key_of = 32'h00000607 ^ 32'h08090a0b;
      3: key_of = 32'h1a1b1c1d ^ 32'h1e1f2021 ^ 32'h00000011 ^ 32'h00002223 ^ 32'h24250000;
      default: key_of = 32'h00000c0d;
    endcase
  endfunction
  function automatic logic [3:0] idx_of(input logic [31:0] x);
    idx_of = 4'h0;
    for (int i = 0; i < 8; i++) idx_of = idx_of ^ x[4*i +: 4];
  endfunction
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_basic();
    phy.send(ST, 64, 0); expect_q(3'h0, 11'd64);
    phy.send(ST ^ 48'h1, 64, 0); expect_none();
    phy.send(ST ^ 48'h800000000000, 64, 0); expect_none();
    phy.send(ST, 1518, 0); expect_q(3'h0, 11'd1518);
    RING_FREE = 8'hfe;
    phy.send(ST, 64, 0); rx_flag(6'h20, 1'b0);
    RING_FREE = 8'hff;
  endtask
  task automatic t_extra();
    EXT_FEAT_EN = 1'b1;
    for (int n = 0; n < 4; n++) begin
      phy.send(XA[48*n +: 48], 64, 0); expect_q(3'h0, 11'd64);
    end
    EXT_FEAT_EN = 1'b0;
    phy.send(XA[191:144], 64, 0); expect_none();
  endtask
  task automatic t_bcast();
    phy.send({48{1'b1}}, 64, 0); expect_none();
    BCAST_EN = 1'b1;
    phy.send({48{1'b1}}, 64, 0); expect_q(3'h0, 11'd64);
    BCAST_EN = 1'b0; PROMISC_EN = 1'b1;
    phy.send(48'h123456789abc, 70, 0); expect_q(3'h0, 11'd70);
    PROMISC_EN = 1'b0;
  endtask
  task automatic t_parse();
    PARSE_EN = 1'b1; EXT_FEAT_EN = 1'b1; TBL_VLD = 1'b1;
    for (int k = 0; k < 4; k++) begin // Parse setup precedes each frame
      KEY_SEL = (k == 3) ? 8'hf8 : 8'h01 << k;
      TBL_WR = 1'b1; TBL_IDX = idx_of(key_of(k)); TBL_KEY = key_of(k); TBL_RING = 3'(k + 4);
      @(negedge CLK);
      TBL_WR = 1'b0;
      phy.send(ST, 80, (k == 3) ? 4 : 0);
      expect_q(3'(k + 4), 11'd80);
    end
    KEY_SEL = 8'h01; DEF_RING_EN = 1'b1; DEF_RING = 3'h3;
    phy.send(XA[47:0], 64, 0); expect_q(3'h3, 11'd64);
    DEF_RING_EN = 1'b0;
    phy.send(XA[47:0], 64, 0); expect_none();
    PARSE_EN = 1'b0; EXT_FEAT_EN = 1'b0;
  endtask
  task automatic t_errors();
    phy.send(ST, 64, 1); rx_flag(6'h01, 1'b0);
    phy.send(ST, 64, 2); rx_flag(6'h01, 1'b0);
    phy.send(ST, 64, 3); rx_flag(6'h02, 1'b0);
    phy.send(ST, 63, 0); rx_flag(6'h04, 1'b0);
    phy.send(ST, 1519, 0); rx_flag(6'h08, 1'b0);
  endtask
  task automatic t_tx();
    // Clear held high throughout: the event edge checks that set wins
    TX_CLR = 7'h7f;
    for (int k = 0; k < 7; k++) begin
      TX_EVT = 7'h01 << k;
      @(negedge CLK);
      TX_EVT = 7'h00;
      chk(TX_STAT, 7'h01 << k); chk(EVT_IRQ, 1);
      @(negedge CLK);
      chk(TX_STAT, 0); chk(EVT_IRQ, 0);
    end
    TX_CLR = 7'h00;
  endtask
  task automatic t_overrun();
    // Sixteen stored words plus the output stage hold seventeen
    repeat (18) phy.send(ST, 64, 0);
    rx_flag(6'h10, 1'b1);
    repeat (17) expect_q(3'h0, 11'd64);
    expect_none();
  endtask
  initial begin
    repeat (2) @(negedge CLK);
    RESET = 1'b0;
    t_basic(); t_extra(); t_bcast(); t_parse(); t_errors(); t_tx(); t_overrun();
    print_verdict();
  end
endmodule // tb_top
